/* File: src/system_reset_status_options_rti.sv */
// System control block: periodic wakeup, reset cause and system options, write-once except the serial bits
`include "sysctl_map.svh"

module system_reset_status_options_rti
  import sysctl_pkg::*;
#(
  parameter int EXT_DIV = `WAKE_EXT_DIV
)
(
  // Clock and resets
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        por_rstn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Reference clocks and power mode
  input  wire logic        ref_1khz,
  input  wire logic        external_ref_clock,
  input  wire logic        ext_ref_clock_enable,
  input  wire logic        ext_ref_stop_enable,
  input  wire logic        stop_mode,
  // Reset sources, valid at reset release
  input  wire logic        cause_por,
  input  wire logic        cause_pin,
  input  wire logic        cause_watchdog,
  input  wire logic        cause_bad_opcode,
  input  wire logic        cause_bad_address,
  input  wire logic        low_voltage_reset,
  input  wire logic        debug_forced_reset_cmd,
  // Mode strap and security
  input  wire logic        mode_select_pin,
  input  wire logic        security_disengaged,
  // Instruction and access checks
  input  wire logic        stop_instr_exec,
  input  wire logic        enter_debug_instr,
  input  wire logic        debug_mode_enable,
  input  wire logic        unimpl_opcode,
  input  wire logic        unimpl_access,
  // Outputs to the system
  output logic             wakeup_irq,
  output logic             watchdog_restart,
  output logic             watchdog_enable,
  output logic [8:0]       watchdog_limit,
  output logic             stop_mode_enable,
  output logic             serial_channel_select,
  output logic             serial_mode_select,
  output logic             debug_pin_enable,
  output logic             reset_pin_enable,
  output logic             bad_opcode_reset,
  output logic             bad_address_reset
);

  // Pin synchronisers
  logic [2:0] ref_sync_q, ref_sync_d, ext_sync_q, ext_sync_d, ms_sync_q, ms_sync_d;
  logic       ref_lvl_q, ref_lvl_d, ext_lvl_q, ext_lvl_d, ms_lvl_q, ms_lvl_d;
  logic       int_tick, ext_tick, ext_run, period_done;

  // Bus state
  logic       wr_pend_q, wr_pend_d;
  reg_sel_t   wr_sel_q, wr_sel_d;
  logic       rd_valid;
  reg_sel_t   rd_sel;
  logic [31:0] hrdata_d;

  // Registers
  init_state_t state_q, state_d;
  logic [7:0] wake_q, wake_d;
  logic [7:0] cause_q, cause_d;
  logic [7:0] opt_q, opt_d;
  logic       rst_pin_q, rst_pin_d;
  logic       locked_q, locked_d;
  logic       restart_d, irq_d, badop_d, badad_d;
  logic [8:0] limit_d;
  logic       wr_wake, wr_cause, wr_opt;

  function automatic logic agreed(input logic [2:0] s, input logic lvl);
    agreed = (s[1] == s[2]) ? s[2] : lvl;
  endfunction

  function automatic reg_sel_t decode(input logic [31:0] a);
    case (a)
      `OFS_WAKE_CTRL:   decode = SEL_WAKE;
      `OFS_RESET_CAUSE: decode = SEL_CAUSE;
      `OFS_SYS_OPTIONS: decode = SEL_OPT;
      default:          decode = SEL_NONE;
    endcase
  endfunction

  wake_timer #(
    .EXT_DIV     (EXT_DIV)
  ) u_wake_timer (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .int_tick    (int_tick),
    .ext_tick    (ext_tick),
    .clk_sel     (wake_q[`WAKE_CLKSEL_BIT]),
    .period_sel  (wake_q[`WAKE_PER_MSB:0]),
    .period_done (period_done)
  );

  // Reference edges after three flops
  always_comb
  begin
    ref_sync_d = {ref_sync_q[1:0], ref_1khz};
    ext_sync_d = {ext_sync_q[1:0], external_ref_clock};
    ms_sync_d  = {ms_sync_q[1:0], mode_select_pin};
    ref_lvl_d  = agreed(ref_sync_q, ref_lvl_q);
    ext_lvl_d  = agreed(ext_sync_q, ext_lvl_q);
    ms_lvl_d   = agreed(ms_sync_q, ms_lvl_q);
    ext_run    = ext_ref_clock_enable && (!stop_mode || ext_ref_stop_enable);
    int_tick   = ref_lvl_d && !ref_lvl_q;
    ext_tick   = ext_lvl_d && !ext_lvl_q && ext_run;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ref_sync_q <= 3'h0;
      ext_sync_q <= 3'h0;
      ref_lvl_q  <= 1'b0;
      ext_lvl_q  <= 1'b0;
    end
    else
    begin
      ref_sync_q <= ref_sync_d;
      ext_sync_q <= ext_sync_d;
      ref_lvl_q  <= ref_lvl_d;
      ext_lvl_q  <= ext_lvl_d;
    end
  end

  always_ff @(posedge hclk)
  begin
    ms_sync_q <= ms_sync_d;
    ms_lvl_q  <= ms_lvl_d;
  end

  // Bus address and data phases, zero wait states
  always_comb
  begin
    rd_valid  = 1'b0;
    rd_sel    = SEL_NONE;
    wr_pend_d = 1'b0;
    wr_sel_d  = SEL_NONE;
    if (hsel && htrans[1] && hready)
    begin
      wr_pend_d = hwrite;
      wr_sel_d  = decode(haddr);
      rd_valid  = !hwrite;
      rd_sel    = decode(haddr);
    end
    wr_wake  = wr_pend_q && (wr_sel_q == SEL_WAKE);
    wr_cause = wr_pend_q && (wr_sel_q == SEL_CAUSE);
    wr_opt   = wr_pend_q && (wr_sel_q == SEL_OPT);
  end

  // Register next values
  always_comb
  begin
    state_d   = state_q;
    wake_d    = wake_q;
    cause_d   = cause_q;
    opt_d     = opt_q;
    rst_pin_d = rst_pin_q;
    locked_d  = locked_q;
    case (state_q)
      ST_HOLD:    state_d = ST_CAPTURE;
      ST_CAPTURE: state_d = ST_RUN;
      ST_RUN:     state_d = ST_RUN;
      default:    state_d = ST_HOLD;
    endcase
    if (state_q == ST_CAPTURE)
    begin
      opt_d[`OPT_DBG_PIN_BIT] = !ms_lvl_q || security_disengaged;
      if (debug_forced_reset_cmd)
      begin
        cause_d = 8'h00;
      end
      else if (cause_por)
      begin
        cause_d = `CAUSE_POR_VALUE;
      end
      else if (low_voltage_reset)
      begin
        cause_d = {cause_q[`CAUSE_POR_BIT], 7'h02};
      end
      else
      begin
        cause_d = 8'h00;
        cause_d[`CAUSE_PIN_BIT]   = cause_pin;
        cause_d[`CAUSE_WDOG_BIT]  = cause_watchdog;
        cause_d[`CAUSE_BADOP_BIT] = cause_bad_opcode;
        cause_d[`CAUSE_BADAD_BIT] = cause_bad_address;
      end
    end
    if (wr_wake)
    begin
      wake_d[`WAKE_CLKSEL_BIT]   = hwdata[`WAKE_CLKSEL_BIT];
      wake_d[`WAKE_IRQEN_BIT]    = hwdata[`WAKE_IRQEN_BIT];
      wake_d[`WAKE_PER_MSB:0]    = hwdata[`WAKE_PER_MSB:0];
    end
    // Period end wins over an acknowledge in the same cycle
    wake_d[`WAKE_FLAG_BIT] = period_done ||
      (wake_q[`WAKE_FLAG_BIT] && !(wr_wake && hwdata[`WAKE_ACK_BIT]));
    wake_d[`WAKE_ACK_BIT] = 1'b0;
    if (wr_opt)
    begin
      opt_d[`OPT_SER_CH_BIT] = hwdata[`OPT_SER_CH_BIT];
      opt_d[`OPT_SER_MS_BIT] = hwdata[`OPT_SER_MS_BIT];
      if (!locked_q)
      begin
        opt_d[`OPT_WDOG_EN_BIT] = hwdata[`OPT_WDOG_EN_BIT];
        opt_d[`OPT_WDOG_TO_BIT] = hwdata[`OPT_WDOG_TO_BIT];
        opt_d[`OPT_STOP_EN_BIT] = hwdata[`OPT_STOP_EN_BIT];
        opt_d[`OPT_DBG_PIN_BIT] = hwdata[`OPT_DBG_PIN_BIT];
        rst_pin_d               = hwdata[`OPT_RST_PIN_BIT];
        locked_d                = 1'b1;
      end
    end
    restart_d = wr_cause || (wr_opt && !locked_q);
    irq_d     = wake_d[`WAKE_FLAG_BIT] && wake_d[`WAKE_IRQEN_BIT];
    limit_d   = opt_d[`OPT_WDOG_TO_BIT] ? `WDOG_LONG_CYCLES : `WDOG_SHORT_CYCLES;
    badop_d   = (stop_instr_exec && !opt_q[`OPT_STOP_EN_BIT]) ||
                (enter_debug_instr && !debug_mode_enable) || unimpl_opcode;
    badad_d   = unimpl_access;
    hrdata_d  = 32'h0000_0000;
    if (rd_valid)
    begin
      case (rd_sel)
        SEL_WAKE:  hrdata_d[7:0] = wake_d;
        SEL_CAUSE: hrdata_d[7:0] = cause_d;
        SEL_OPT:   hrdata_d[7:0] = {opt_d[7:1], rst_pin_d};
        default:   hrdata_d      = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q          <= ST_HOLD;
      wake_q           <= 8'h00;
      opt_q            <= `OPT_RESET_VALUE;
      locked_q         <= 1'b0;
      wr_pend_q        <= 1'b0;
      wr_sel_q         <= SEL_NONE;
      hrdata           <= 32'h0000_0000;
      hreadyout        <= 1'b0;
      hresp            <= 1'b0;
      wakeup_irq       <= 1'b0;
      watchdog_restart <= 1'b0;
      watchdog_limit   <= `WDOG_LONG_CYCLES;
      bad_opcode_reset <= 1'b0;
      bad_address_reset <= 1'b0;
    end
    else
    begin
      state_q          <= state_d;
      wake_q           <= wake_d;
      opt_q            <= opt_d;
      locked_q         <= locked_d;
      wr_pend_q        <= wr_pend_d;
      wr_sel_q         <= wr_sel_d;
      hrdata           <= hrdata_d;
      hreadyout        <= (state_d == ST_RUN);
      hresp            <= 1'b0;
      wakeup_irq       <= irq_d;
      watchdog_restart <= restart_d;
      watchdog_limit   <= limit_d;
      bad_opcode_reset <= badop_d;
      bad_address_reset <= badad_d;
    end
  end

  // Power-on domain: kept across other resets
  always_ff @(posedge hclk or negedge por_rstn)
  begin
    if (!por_rstn)
    begin
      cause_q   <= `CAUSE_POR_VALUE;
      rst_pin_q <= 1'b0;
    end
    else
    begin
      cause_q   <= cause_d;
      rst_pin_q <= rst_pin_d;
    end
  end

  assign watchdog_enable       = opt_q[`OPT_WDOG_EN_BIT];
  assign stop_mode_enable      = opt_q[`OPT_STOP_EN_BIT];
  assign serial_channel_select = opt_q[`OPT_SER_CH_BIT];
  assign serial_mode_select    = opt_q[`OPT_SER_MS_BIT];
  assign debug_pin_enable      = opt_q[`OPT_DBG_PIN_BIT];
  assign reset_pin_enable      = rst_pin_q;

  irq_mask_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !wake_q[`WAKE_IRQEN_BIT] |-> !wakeup_irq)
    else $error("wakeup irq raised while enable clear");

  period_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wake_q[2:0] == 3'h0 |=> !period_done)
    else $error("period end while timer disabled");

  flag_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    period_done |=> wake_q[`WAKE_FLAG_BIT] && (wakeup_irq == wake_q[`WAKE_IRQEN_BIT]))
    else $error("period end did not set flag and irq");

  cause_restart_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_cause && state_q == ST_RUN |=> watchdog_restart && $stable(cause_q))
    else $error("cause write did not restart watchdog or changed flags");

  opt_lock_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_opt && locked_q |=> $stable(opt_q[7:5]) && $stable(opt_q[1]) && $stable(rst_pin_q))
    else $error("locked options changed");

  serial_free_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_opt |=> serial_channel_select == $past(hwdata[3]) &&
               serial_mode_select == $past(hwdata[2]))
    else $error("serial bits not written");

  bad_opcode_a: assert property (@(posedge hclk) disable iff (!hresetn)
    stop_instr_exec && !stop_mode_enable |=> bad_opcode_reset)
    else $error("disabled stop did not raise opcode reset");

  bad_addr_a: assert property (@(posedge hclk) disable iff (!hresetn)
    unimpl_access |=> bad_address_reset)
    else $error("bad access did not raise address reset");

  wdog_limit_a: assert property (@(posedge hclk) disable iff (!hresetn)
    watchdog_limit == (opt_q[`OPT_WDOG_TO_BIT] ? `WDOG_LONG_CYCLES : `WDOG_SHORT_CYCLES))
    else $error("watchdog limit mismatch");

  por_cause_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == ST_CAPTURE && cause_por && !debug_forced_reset_cmd |=> cause_q == 8'h82)
    else $error("power-on cause value wrong");

endmodule

/* File: src/sysctl_map.svh */
// Register offsets, field positions, reset values and counts of the system control block
`ifndef SYSCTL_MAP_SVH
`define SYSCTL_MAP_SVH

`define OFS_WAKE_CTRL     32'h0000_0000
`define OFS_RESET_CAUSE   32'h0000_0004
`define OFS_SYS_OPTIONS   32'h0000_0008

`define WAKE_FLAG_BIT     7
`define WAKE_ACK_BIT      6
`define WAKE_CLKSEL_BIT   5
`define WAKE_IRQEN_BIT    4
`define WAKE_PER_MSB      2

`define CAUSE_POR_BIT     7
`define CAUSE_PIN_BIT     6
`define CAUSE_WDOG_BIT    5
`define CAUSE_BADOP_BIT   4
`define CAUSE_BADAD_BIT   3
`define CAUSE_LOWV_BIT    1
`define CAUSE_POR_VALUE   8'h82

`define OPT_WDOG_EN_BIT   7
`define OPT_WDOG_TO_BIT   6
`define OPT_STOP_EN_BIT   5
`define OPT_SER_CH_BIT    3
`define OPT_SER_MS_BIT    2
`define OPT_DBG_PIN_BIT   1
`define OPT_RST_PIN_BIT   0
`define OPT_FREE_MASK     8'h0C
`define OPT_RESET_VALUE   8'hC2

`define WAKE_EXT_DIV      32
`define WAKE_PER_1        11'h008
`define WAKE_PER_2        11'h020
`define WAKE_PER_3        11'h040
`define WAKE_PER_4        11'h080
`define WAKE_PER_5        11'h100
`define WAKE_PER_6        11'h200
`define WAKE_PER_7        11'h400

`define WDOG_SHORT_CYCLES 9'h020
`define WDOG_LONG_CYCLES  9'h100

`endif

/* File: src/sysctl_pkg.sv */
// Types shared by the system control block
package sysctl_pkg;

  typedef enum logic [1:0] {
    ST_HOLD    = 2'b00,
    ST_CAPTURE = 2'b01,
    ST_RUN     = 2'b11
  } init_state_t;

  typedef enum logic [1:0] {
    SEL_WAKE  = 2'b00,
    SEL_CAUSE = 2'b01,
    SEL_OPT   = 2'b10,
    SEL_NONE  = 2'b11
  } reg_sel_t;

endpackage

/* File: src/wake_timer.sv */
// Periodic wakeup timer: external reference divider and period counter
`include "sysctl_map.svh"

module wake_timer
  import sysctl_pkg::*;
#(
  parameter int EXT_DIV = `WAKE_EXT_DIV
)
(
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Reference ticks, one cycle each
  input  wire logic       int_tick,
  input  wire logic       ext_tick,
  // Control
  input  wire logic       clk_sel,
  input  wire logic [2:0] period_sel,
  // Period end pulse
  output logic            period_done
);

  localparam int DW = (EXT_DIV > 1) ? $clog2(EXT_DIV) : 1;

  if (EXT_DIV < 2)
  begin : bad_div
    $error("EXT_DIV must be at least 2");
  end

  logic [DW-1:0] div_q, div_d;
  logic [10:0]   cnt_q, cnt_d;
  logic          done_d;
  logic          src_tick;

  function automatic logic [10:0] period_len(input logic [2:0] sel);
    case (sel)
      3'h1:    period_len = `WAKE_PER_1;
      3'h2:    period_len = `WAKE_PER_2;
      3'h3:    period_len = `WAKE_PER_3;
      3'h4:    period_len = `WAKE_PER_4;
      3'h5:    period_len = `WAKE_PER_5;
      3'h6:    period_len = `WAKE_PER_6;
      3'h7:    period_len = `WAKE_PER_7;
      default: period_len = 11'h000;
    endcase
  endfunction

  always_comb
  begin
    div_d    = div_q;
    src_tick = 1'b0;
    if (ext_tick)
    begin
      div_d = (div_q == DW'(EXT_DIV - 1)) ? '0 : div_q + DW'(1);
    end
    if (clk_sel)
    begin
      src_tick = ext_tick && (div_q == DW'(EXT_DIV - 1));
    end
    else
    begin
      src_tick = int_tick;
    end
    cnt_d  = cnt_q;
    done_d = 1'b0;
    if (period_sel == 3'h0)
    begin
      cnt_d = 11'h000;
    end
    else if (src_tick)
    begin
      if (cnt_q >= period_len(period_sel) - 11'h001)
      begin
        cnt_d  = 11'h000;
        done_d = 1'b1;
      end
      else
      begin
        cnt_d = cnt_q + 11'h001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_q       <= '0;
      cnt_q       <= 11'h000;
      period_done <= 1'b0;
    end
    else
    begin
      div_q       <= div_d;
      cnt_q       <= cnt_d;
      period_done <= done_d;
    end
  end

endmodule

/* File: test/system_reset_status_options_rti_bench.sv */
// Self-checking bench of the system control block
`include "sysctl_map.svh"

module system_reset_status_options_rti_bench
  import sysctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int DIV = 2;

  // Bus and resets
  logic        hclk = 1'b0, hresetn = 1'b0, por_rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic        hready, hreadyout, hresp;
  // Pins and levels
  logic        ref_1khz = 1'b0, external_ref_clock = 1'b0, ext_ref_clock_enable = 1'b0;
  logic        ext_ref_stop_enable = 1'b0, stop_mode = 1'b0, cause_por = 1'b1;
  logic        cause_pin = 1'b0, cause_watchdog = 1'b0, cause_bad_opcode = 1'b0;
  logic        cause_bad_address = 1'b0, low_voltage_reset = 1'b0;
  logic        debug_forced_reset_cmd = 1'b0, mode_select_pin = 1'b0;
  logic        security_disengaged = 1'b0, stop_instr_exec = 1'b0, enter_debug_instr = 1'b0;
  logic        debug_mode_enable = 1'b0, unimpl_opcode = 1'b0, unimpl_access = 1'b0;
  // Outputs
  logic        wakeup_irq, watchdog_restart, watchdog_enable, stop_mode_enable;
  logic        serial_channel_select, serial_mode_select, debug_pin_enable;
  logic        reset_pin_enable, bad_opcode_reset, bad_address_reset;
  logic [8:0]  watchdog_limit;
  // Bench state
  logic [31:0] rdv;
  logic [7:0]  cexp = 8'h00, oexp = 8'h00, v;
  logic [6:0]  c = 7'h20;
  logic        ms = 1'b0, sec = 1'b0, dme, rsp;
  int          n_errors = 0, checks = 0;

  assign hready = hreadyout;

  always #10 hclk = ~hclk;

  system_reset_status_options_rti #(.EXT_DIV(DIV)) u_system_reset_status_options_rti (
    .hclk, .hresetn, .por_rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .ref_1khz, .external_ref_clock, .ext_ref_clock_enable,
    .ext_ref_stop_enable, .stop_mode, .cause_por, .cause_pin, .cause_watchdog,
    .cause_bad_opcode, .cause_bad_address, .low_voltage_reset, .debug_forced_reset_cmd,
    .mode_select_pin, .security_disengaged, .stop_instr_exec, .enter_debug_instr,
    .debug_mode_enable, .unimpl_opcode, .unimpl_access, .wakeup_irq, .watchdog_restart,
    .watchdog_enable, .watchdog_limit, .stop_mode_enable, .serial_channel_select,
    .serial_mode_select, .debug_pin_enable, .reset_pin_enable, .bad_opcode_reset,
    .bad_address_reset
  );

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // Waits for an edge with the slave ready, bounded
  task automatic rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
      if (n > 20)
      begin
        n_errors++;
        end_sim();
      end
    end
    while (hreadyout !== 1'b1);
  endtask

  task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    rdy();
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= {24'h00_0000, d};
    rdy();
    rdv = hrdata;
    rsp = hresp;
  endtask

  task automatic rdc(input string nm, input logic [31:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(nm, {24'h00_0000, e}, rdv);
    chk("bus response", 32'h0000_0000, {31'h0000_0000, rsp});
  endtask

  function automatic logic [7:0] cause_exp(input logic [6:0] cz, input logic [7:0] old);
    if (cz[6])
      return 8'h00;
    if (cz[5])
      return 8'h82;
    if (cz[4])
      return {old[7], 7'h02};
    return {1'b0, cz[3:0], 3'b000};
  endfunction

  task automatic do_reset(input logic por);
    @(posedge hclk);
    mode_select_pin     <= ms;
    security_disengaged <= sec;
    {debug_forced_reset_cmd, cause_por, low_voltage_reset, cause_pin, cause_watchdog,
     cause_bad_opcode, cause_bad_address} <= c;
    repeat (4) @(posedge hclk);
    hresetn  <= 1'b0;
    por_rstn <= ~por;
    repeat (4) @(posedge hclk);
    hresetn  <= 1'b1;
    por_rstn <= 1'b1;
    repeat (3) @(posedge hclk);
    {debug_forced_reset_cmd, cause_por, low_voltage_reset, cause_pin, cause_watchdog,
     cause_bad_opcode, cause_bad_address} <= 7'h00;
  endtask

  // One-cycle pulse on one check input, then the pair of illegal resets
  task automatic strike(input int k, input logic [1:0] exp);
    @(posedge hclk);
    {unimpl_access, unimpl_opcode, enter_debug_instr, stop_instr_exec} <= 4'(1 << k);
    @(posedge hclk);
    {unimpl_access, unimpl_opcode, enter_debug_instr, stop_instr_exec} <= 4'h0;
    #1 chk("illegal reset pair", {30'h0, exp}, {30'h0, bad_address_reset, bad_opcode_reset});
  endtask

  // Rising edges on one reference pin, each level held four cycles
  task automatic edges(input int n, input logic ext);
    repeat (n)
    begin
      {external_ref_clock, ref_1khz} <= ext ? 2'b10 : 2'b01;
      repeat (4) @(posedge hclk);
      {external_ref_clock, ref_1khz} <= 2'b00;
      repeat (4) @(posedge hclk);
    end
  endtask

  task automatic wake(input logic [2:0] p, input logic ext, input logic ee, input logic se,
                      input logic sm, input logic fire);
    logic       en;
    logic [7:0] cv;
    int         n;
    en = 1'($urandom);
    n  = (p == 3'd1 ? 8 : 8 << p) * (ext ? DIV : 1);
    cv = {2'b00, ext, en, 1'b0, p};
    bus(1'b1, `OFS_WAKE_CTRL, 8'h40);
    ext_ref_clock_enable <= ee;
    ext_ref_stop_enable  <= se;
    stop_mode            <= sm;
    bus(1'b1, `OFS_WAKE_CTRL, cv);
    edges(n - 1, ext);
    rdc("wake control early", `OFS_WAKE_CTRL, cv);
    edges(1, ext);
    repeat (4) @(posedge hclk);
    rdc("wake control end", `OFS_WAKE_CTRL, cv | {fire, 7'h00});
    #1 chk("wakeup irq", fire & en, wakeup_irq);
    bus(1'b1, `OFS_WAKE_CTRL, cv | 8'h40);
    rdc("wake control acked", `OFS_WAKE_CTRL, cv);
    #1 chk("wakeup irq acked", 0, wakeup_irq);
  endtask

  initial
  begin
    v = 8'($urandom(32'h2374_ca81));
    repeat (4) @(posedge hclk);
    hresetn  <= 1'b1;
    por_rstn <= 1'b1;
    repeat (3) @(posedge hclk);
    {cause_por, debug_forced_reset_cmd} <= 2'b00;
    for (int i = 0; i < 8; i++)
    begin
      if (i > 0)
      begin
        c   = i == 3 ? 7'h20 : {i == 5, 1'b0, i == 4 || i == 7, 4'($urandom)};
        ms  = 1'($urandom);
        sec = 1'($urandom);
        do_reset(i == 3);
      end
      cexp = cause_exp(c, cexp);
      oexp = {6'b110000, ~ms | sec, (i == 0 || i == 3) ? 1'b0 : oexp[0]};
      rdc("reset cause", `OFS_RESET_CAUSE, cexp);
      rdc("options after reset", `OFS_SYS_OPTIONS, oexp);
      bus(1'b1, `OFS_RESET_CAUSE, 8'($urandom));
      #1 chk("watchdog restart", 1, watchdog_restart);
      rdc("reset cause kept", `OFS_RESET_CAUSE, cexp);
      v    = 8'($urandom);
      oexp = v & 8'hEF;
      bus(1'b1, `OFS_SYS_OPTIONS, v);
      rdc("options first write", `OFS_SYS_OPTIONS, oexp);
      chk("option outputs", {oexp[7], oexp[5], oexp[3:0]}, {watchdog_enable, stop_mode_enable,
          serial_channel_select, serial_mode_select, debug_pin_enable, reset_pin_enable});
      chk("watchdog limit", oexp[6] ? 9'h100 : 9'h020, watchdog_limit);
      v    = 8'($urandom);
      oexp = (oexp & 8'hF3) | (v & 8'h0C);
      bus(1'b1, `OFS_SYS_OPTIONS, v);
      rdc("options later write", `OFS_SYS_OPTIONS, oexp);
      dme = 1'($urandom);
      debug_mode_enable <= dme;
      strike(0, {1'b0, ~oexp[5]});
      strike(1, {1'b0, ~dme});
      strike(2, 2'b01);
      strike(3, 2'b10);
      bus(1'b1, 32'h0000_000C, 8'hFF);
      rdc("unmapped", 32'h0000_000C, 8'h00);
    end
    for (int p = 0; p < 8; p++)
      wake(3'(p), 1'b0, 1'b0, 1'b0, 1'($urandom), p != 0);
    wake(3'd1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
    wake(3'd1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    wake(3'd1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    wake(3'd2, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    end_sim();
  end
endmodule
